// >>> design/can_tef_pkg.sv
// package: register map, field positions and reset values of the event fifo status block
// assumes a 16-bit register port with word indices; used by design and bench alike
package can_tef_pkg;
    // ************************************************************
    // register indices
    // ************************************************************
    localparam logic [5:0] ADDR_EVENT_CONTROL = 6'h00;
    localparam logic [5:0] ADDR_EVENT_STATUS = 6'h01;
    localparam logic [5:0] ADDR_EVENT_UA_LOW = 6'h02;
    localparam logic [5:0] ADDR_EVENT_UA_HIGH = 6'h03;
    localparam logic [5:0] ADDR_FIFO_DIR = 6'h04;
    localparam logic [5:0] ADDR_MSG_UA_BASE = 6'h10;
    localparam logic [5:0] ADDR_MSG_UA_LAST = 6'h1F;
    // ************************************************************
    // control fields
    // ************************************************************
    localparam int CTL_ADVANCE_TAIL = 8;
    localparam int CTL_STAMP_EN = 5;
    localparam int CTL_OVF_IE = 3;
    localparam int CTL_FULL_IE = 2;
    localparam int CTL_HALF_IE = 1;
    localparam int CTL_NONEMPTY_IE = 0;
    localparam logic [15:0] CTL_RW_MASK = 16'h002F;
    // ************************************************************
    // status fields
    // ************************************************************
    localparam int STA_OVF = 3;
    localparam int STA_FULL = 2;
    localparam int STA_HALF = 1;
    localparam int STA_NONEMPTY = 0;
    localparam logic [15:0] RESET_CONTROL = 16'h0000;
    localparam logic [6:0] RESET_DIRECTION = 7'h00;
    localparam logic [15:0] READ_ZERO = 16'h0000;
    // ************************************************************
    // element sizing in bytes
    // ************************************************************
    localparam logic [31:0] EVENT_ELEM_BYTES = 32'h0000_0008;
    localparam logic [31:0] EVENT_STAMP_BYTES = 32'h0000_0004;
endpackage

// >>> design/tef_ring_pointer.sv
// ring pointer: head and tail indices with occupancy for one fifo
// assumes push and pop come as one-cycle pulses from the owner
`timescale 1ns/1ps
module tef_ring_pointer #(
    parameter int DEPTH = 8,
    parameter int IW = 5
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic push,
    input wire logic pop,
    output logic [IW-1:0] headIdx,
    output logic [IW-1:0] tailIdx,
    output logic [IW:0] occupancy
);
    localparam logic [IW-1:0] LAST_IDX = IW'(DEPTH - 1);
    localparam logic [IW:0] DEPTH_W = (IW + 1)'(DEPTH);

    logic doPush;
    logic doPop;

    // full refuses the push so nothing unread is overwritten
    assign doPush = push && (occupancy != DEPTH_W);
    assign doPop = pop && (occupancy != '0);

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            headIdx <= '0;
        end else if (doPush) begin
            headIdx <= (headIdx == LAST_IDX) ? '0 : headIdx + 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            tailIdx <= '0;
        end else if (doPop) begin
            tailIdx <= (tailIdx == LAST_IDX) ? '0 : tailIdx + 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            occupancy <= '0;
        end else if (doPush && !doPop) begin
            occupancy <= occupancy + 1'b1;
        end else if (doPop && !doPush) begin
            occupancy <= occupancy - 1'b1;
        end
    end
endmodule

// >>> design/can_tx_event_fifo_status_ptrs.sv
// event fifo status, interrupt enables and user-address pointers of a can controller
// assumes a register port with one-cycle strobes, read data one cycle later,
// and event/message activity signalled as one-cycle pulses by the can core
//
// The placing of the registers and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
// Function
// [R1] writing advance_tail moves the event fifo tail by exactly one element
// [R2] event_stamp_enable set makes each stored event element carry a timestamp
// [R3] four enable bits gate overflow, full, half and nonempty interrupt requests
// [R4] overflow flag set on overflow event, cleared by hardware, zero otherwise
// [R5] full flag is one exactly when every element is occupied
// [R6] half flag is one when occupancy reaches half the depth
// [R7] nonempty flag is one whenever at least one element is held
// [R8] full, half and nonempty are live read-only views; writes ignored
// [R9] transmit message fifo user address reads the head address
// [R10] receive message fifo user address reads the tail address
// [R11] event fifo user address, high and low halves, reads the tail address
// [R12] software reads user addresses only outside configuration mode
// [R13] unused status bits read zero; all flags reset to zero
// [R14] event arriving while full is an overflow and is not stored
module can_tx_event_fifo_status_ptrs #(
    parameter int EVENT_DEPTH = 8,
    parameter int MSG_DEPTH = 8,
    parameter int NUM_MSG = 7,
    parameter logic [31:0] EVENT_BASE = 32'h0000_0400,
    parameter logic [31:0] MSG_BASE = 32'h0000_0000,
    parameter logic [31:0] MSG_ELEM_BYTES = 32'h0000_0010
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [5:0] regAddr,
    input wire logic [15:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic eventPush,
    input wire logic overflowClear,
    input wire logic [6:0] msgPush,
    input wire logic [6:0] msgPop,
    output logic [15:0] regRdData,
    output logic eventStampEnable,
    output logic eventIrq,
    output logic [7:0] eventWriteIdx
);
    localparam int IW = 5;
    localparam logic [IW:0] EVENT_DEPTH_W = (IW + 1)'(EVENT_DEPTH);
    localparam logic [IW:0] EVENT_HALF_W = (IW + 1)'((EVENT_DEPTH + 1) / 2);

    // ************************************************************
    // helpers
    // ************************************************************
    // element address from base, index and element size
    function automatic logic [31:0] elemAddr(input logic [31:0] base, input logic [IW-1:0] idx,
                                             input logic [31:0] size);
        logic [31:0] prod;
        prod = 32'(idx) * size;
        elemAddr = base + prod;
    endfunction

    // ************************************************************
    // state
    // ************************************************************
    logic [15:0] control_ff;
    logic [6:0] direction_ff;
    logic overflow_ff;
    logic advance_ff;
    logic [IW-1:0] evHead;
    logic [IW-1:0] evTail;
    logic [IW:0] evOcc;
    logic [IW-1:0] msgHead [NUM_MSG];
    logic [IW-1:0] msgTail [NUM_MSG];
    logic [3:0] irqRequest;
    logic [31:0] msgUa [NUM_MSG];
    logic evFull;
    logic evHalf;
    logic evNonEmpty;
    logic [31:0] evElemBytes;
    logic [31:0] evUa;
    logic [15:0] statusWord;
    logic [15:0] nxt_rdData;
    logic wrControl;

    assign wrControl = regWrite && (regAddr == can_tef_pkg::ADDR_EVENT_CONTROL);

    // ************************************************************
    // control register
    // ************************************************************
    // [R3] enable bits stored
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            control_ff <= can_tef_pkg::RESET_CONTROL;
        end else if (wrControl) begin
            control_ff <= regWrData & can_tef_pkg::CTL_RW_MASK;
        end
    end

    // direction bit per message fifo, set means transmit
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            direction_ff <= can_tef_pkg::RESET_DIRECTION;
        end else if (regWrite && regAddr == can_tef_pkg::ADDR_FIFO_DIR) begin
            direction_ff <= regWrData[6:0];
        end
    end

    // [R1] one-cycle advance pulse
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            advance_ff <= 1'b0;
        end else begin
            advance_ff <= wrControl && regWrData[can_tef_pkg::CTL_ADVANCE_TAIL];
        end
    end

    // ************************************************************
    // event fifo pointers
    // ************************************************************
    // [R1] tail moves by one per advance
    tef_ring_pointer #(
        .DEPTH(EVENT_DEPTH),
        .IW(IW)
    ) u_event_ptr (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .push(eventPush),
        .pop(advance_ff),
        .headIdx(evHead),
        .tailIdx(evTail),
        .occupancy(evOcc)
    );

    // [R5] full when all occupied
    assign evFull = (evOcc == EVENT_DEPTH_W);
    // [R6] half at or above half
    assign evHalf = (evOcc >= EVENT_HALF_W);
    // [R7] nonempty when any held
    assign evNonEmpty = (evOcc != '0);

    // [R14] push while full is overflow
    // [R4] set beats hardware clear
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            overflow_ff <= 1'b0;
        end else if (eventPush && evFull) begin
            overflow_ff <= 1'b1;
        end else if (overflowClear) begin
            overflow_ff <= 1'b0;
        end
    end

    // [R2] stamped elements are longer
    assign evElemBytes = control_ff[can_tef_pkg::CTL_STAMP_EN] ?
        can_tef_pkg::EVENT_ELEM_BYTES + can_tef_pkg::EVENT_STAMP_BYTES : can_tef_pkg::EVENT_ELEM_BYTES;
    // [R11] tail address of event fifo
    assign evUa = elemAddr(EVENT_BASE, evTail, evElemBytes);

    // ************************************************************
    // message fifo pointers
    // ************************************************************
    // head when transmit, tail when receive
    generate
        for (genvar g = 0; g < NUM_MSG; g++) begin : gen_msg
            tef_ring_pointer #(
                .DEPTH(MSG_DEPTH),
                .IW(IW)
            ) u_msg_ptr (
                .clk_sys(clk_sys),
                .reset_n(reset_n),
                .push(msgPush[g]),
                .pop(msgPop[g]),
                .headIdx(msgHead[g]),
                .tailIdx(msgTail[g]),
                .occupancy()
            );
            // [R9] transmit reads head
            // [R10] receive reads tail
            assign msgUa[g] = elemAddr(MSG_BASE + 32'(g) * 32'(MSG_DEPTH) * MSG_ELEM_BYTES,
                                       direction_ff[g] ? msgHead[g] : msgTail[g], MSG_ELEM_BYTES);
        end
    endgenerate

    // ************************************************************
    // read path
    // ************************************************************
    // [R8] live flags, never written
    // [R13] upper bits zero
    always_comb begin
        statusWord = can_tef_pkg::READ_ZERO;
        statusWord[can_tef_pkg::STA_OVF] = overflow_ff;
        statusWord[can_tef_pkg::STA_FULL] = evFull;
        statusWord[can_tef_pkg::STA_HALF] = evHalf;
        statusWord[can_tef_pkg::STA_NONEMPTY] = evNonEmpty;
    end

    // user addresses are not gated: there is no configuration mode input to gate them with
    always_comb begin
        nxt_rdData = can_tef_pkg::READ_ZERO;
        if (regAddr == can_tef_pkg::ADDR_EVENT_CONTROL) begin
            nxt_rdData = control_ff;
        end else if (regAddr == can_tef_pkg::ADDR_EVENT_STATUS) begin
            nxt_rdData = statusWord;
        end else if (regAddr == can_tef_pkg::ADDR_EVENT_UA_LOW) begin
            nxt_rdData = evUa[15:0];
        end else if (regAddr == can_tef_pkg::ADDR_EVENT_UA_HIGH) begin
            nxt_rdData = evUa[31:16];
        end else if (regAddr == can_tef_pkg::ADDR_FIFO_DIR) begin
            nxt_rdData = {9'h000, direction_ff};
        end else if (regAddr >= can_tef_pkg::ADDR_MSG_UA_BASE && regAddr <= can_tef_pkg::ADDR_MSG_UA_LAST) begin
            for (int i = 0; i < NUM_MSG; i++) begin
                if (regAddr[3:1] == 3'(i + 1)) begin
                    nxt_rdData = regAddr[0] ? msgUa[i][31:16] : msgUa[i][15:0];
                end
            end
        end
    end

    // read data only in the cycle after the strobe
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            regRdData <= can_tef_pkg::READ_ZERO;
        end else begin
            regRdData <= regRead ? nxt_rdData : can_tef_pkg::READ_ZERO;
        end
    end

    // ************************************************************
    // outputs to the core
    // ************************************************************
    // [R2] stamp request to the writer
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            eventStampEnable <= 1'b0;
        end else begin
            eventStampEnable <= control_ff[can_tef_pkg::CTL_STAMP_EN];
        end
    end

    // [R3] each condition gated by its enable
    always_comb begin
        irqRequest = 4'h0;
        irqRequest[can_tef_pkg::STA_OVF] = overflow_ff && control_ff[can_tef_pkg::CTL_OVF_IE];
        irqRequest[can_tef_pkg::STA_FULL] = evFull && control_ff[can_tef_pkg::CTL_FULL_IE];
        irqRequest[can_tef_pkg::STA_HALF] = evHalf && control_ff[can_tef_pkg::CTL_HALF_IE];
        irqRequest[can_tef_pkg::STA_NONEMPTY] = evNonEmpty && control_ff[can_tef_pkg::CTL_NONEMPTY_IE];
    end

    // one shared line; software tells the sources apart by the status flags
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            eventIrq <= 1'b0;
        end else begin
            eventIrq <= |irqRequest;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            eventWriteIdx <= 8'h00;
        end else begin
            eventWriteIdx <= 8'(evHead);
        end
    end
endmodule

// >>> bench/can_tef_status_monitor.sv
// checker: port-level properties of the event fifo status block
// assumes one clock domain and the register map of the package
`timescale 1ns/1ps
module can_tef_status_monitor #(
    parameter int EVENT_DEPTH = 8
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [5:0] regAddr,
    input wire logic [15:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic eventPush,
    input wire logic [15:0] regRdData,
    input wire logic eventStampEnable,
    input wire logic eventIrq,
    input wire logic [7:0] eventWriteIdx
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    // ****
    // sequences
    // ****
    sequence s_ctl_write;
        regWrite && regAddr == can_tef_pkg::ADDR_EVENT_CONTROL;
    endsequence
    // three quiet cycles let the registered outputs settle
    sequence s_ctl_quiet;
        (!(regWrite && regAddr == can_tef_pkg::ADDR_EVENT_CONTROL))[*3];
    endsequence
    // ****
    // properties
    // ****
    property p_stamp;
        s_ctl_write ##1 s_ctl_quiet |-> eventStampEnable == $past(regWrData[5], 3);
    endproperty
    a_stamp: assert property (p_stamp) else $error("stamp output does not follow control");
    property p_irq_off;
        s_ctl_write ##0 (regWrData[3:0] == 4'h0) ##1 s_ctl_quiet |-> !eventIrq;
    endproperty
    a_irq_off: assert property (p_irq_off) else $error("irq raised with all enables clear");
    property p_rd_idle;
        !$past(regRead) |-> regRdData == 16'h0000;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
    property p_unmapped;
        regRead && regAddr > 6'h04 && regAddr < 6'h12 |=> regRdData == 16'h0000;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_sta_upper;
        regRead && regAddr == can_tef_pkg::ADDR_EVENT_STATUS |=> regRdData[15:4] == 12'h000;
    endproperty
    a_sta_upper: assert property (p_sta_upper) else $error("status upper bits not zero");
    property p_ctl_read;
        regRead && regAddr == can_tef_pkg::ADDR_EVENT_CONTROL |=> regRdData[15:6] == 10'h000 && !regRdData[4];
    endproperty
    a_ctl_read: assert property (p_ctl_read) else $error("control read shows advance or unused bits");
    property p_idx_cause;
        $changed(eventWriteIdx) |-> $past(eventPush) || $past(eventPush, 2);
    endproperty
    a_idx_cause: assert property (p_idx_cause) else $error("write index moved without push");
    property p_idx_step;
        $changed(eventWriteIdx) |-> eventWriteIdx == 8'((32'($past(eventWriteIdx)) + 1) % EVENT_DEPTH);
    endproperty
    a_idx_step: assert property (p_idx_step) else $error("write index step not one");
endmodule
bind can_tx_event_fifo_status_ptrs can_tef_status_monitor #(.EVENT_DEPTH(EVENT_DEPTH)) mon (
    .clk_sys(clk_sys), .reset_n(reset_n), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .eventPush(eventPush), .regRdData(regRdData),
    .eventStampEnable(eventStampEnable), .eventIrq(eventIrq), .eventWriteIdx(eventWriteIdx));

// >>> bench/can_tx_event_fifo_status_ptrs_bench.sv
// bench: register-level tests of the event fifo status block
// assumes package and design compiled first; checker bound from its own file
`timescale 1ns/1ps
module can_tx_event_fifo_status_ptrs_bench;
    // ****
    // design and stimulus
    // ****
    localparam logic [31:0] EV_BASE = 32'h0000_0400;
    localparam logic [31:0] MSG_ELEM = 32'h0000_0010;
    localparam int MDEPTH = 8;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic [5:0] regAddr = 6'h00;
    logic [15:0] regWrData = 16'h0000;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic eventPush = 1'b0;
    logic overflowClear = 1'b0;
    logic [6:0] msgPush = 7'h00;
    logic [6:0] msgPop = 7'h00;
    logic [15:0] regRdData;
    logic eventStampEnable;
    logic eventIrq;
    logic [7:0] eventWriteIdx;
    logic [15:0] rdVal;
    logic [31:0] expUa;
    int n_errors = 0;
    int num_checks = 0;
    always #50 clk_sys = ~clk_sys;
    can_tx_event_fifo_status_ptrs #(.EVENT_DEPTH(8), .MSG_DEPTH(MDEPTH), .NUM_MSG(7), .EVENT_BASE(EV_BASE),
        .MSG_BASE(32'h0000_0000), .MSG_ELEM_BYTES(MSG_ELEM)) DUT (
        .clk_sys(clk_sys), .reset_n(reset_n), .regAddr(regAddr), .regWrData(regWrData),
        .regWrite(regWrite), .regRead(regRead), .eventPush(eventPush), .overflowClear(overflowClear),
        .msgPush(msgPush), .msgPop(msgPop), .regRdData(regRdData), .eventStampEnable(eventStampEnable),
        .eventIrq(eventIrq), .eventWriteIdx(eventWriteIdx));
    // ****
    // tasks
    // ****
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] expected);
        num_checks++;
        if (seen !== expected) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, expected, seen);
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        regAddr <= a;
        regWrData <= d;
        regWrite <= 1'b1;
        @(posedge clk_sys);
        regWrite <= 1'b0;
    endtask
    // read data stand only in the cycle after the read edge
    task automatic rd(input logic [5:0] a);
        @(posedge clk_sys);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk_sys);
        regRead <= 1'b0;
        #1;
        rdVal = regRdData;
    endtask
    task automatic pulse(input logic ev, input logic oc, input logic [6:0] mp, input logic [6:0] mo);
        @(posedge clk_sys);
        eventPush <= ev;
        overflowClear <= oc;
        msgPush <= mp;
        msgPop <= mo;
        @(posedge clk_sys);
        eventPush <= 1'b0;
        overflowClear <= 1'b0;
        msgPush <= 7'h00;
        msgPop <= 7'h00;
        @(posedge clk_sys);
    endtask
    task automatic finish_test;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // ****
    // sequence
    // ****
    initial begin
        repeat (20000) @(posedge clk_sys);
        n_errors++;
        finish_test();
    end
    initial begin
        repeat (4) @(posedge clk_sys);
        reset_n <= 1'b1;
        rd(can_tef_pkg::ADDR_EVENT_STATUS);
        chk("status reset", rdVal, 16'h0000);
        wr(can_tef_pkg::ADDR_EVENT_CONTROL, 16'hFFFF);
        repeat (2) @(posedge clk_sys);
        rd(can_tef_pkg::ADDR_EVENT_CONTROL);
        chk("control", rdVal, 16'h002F);
        chk("stamp on", eventStampEnable, 1'b1);
        chk("irq empty", eventIrq, 1'b0);
        rd(can_tef_pkg::ADDR_EVENT_UA_HIGH);
        chk("event ua high", rdVal, EV_BASE[31:16]);
        pulse(1'b1, 1'b0, 7'h00, 7'h00);
        rd(can_tef_pkg::ADDR_EVENT_STATUS);
        chk("status one", rdVal, 16'h0001);
        chk("irq nonempty", eventIrq, 1'b1);
        wr(can_tef_pkg::ADDR_EVENT_CONTROL, 16'h0000);
        repeat (3) @(posedge clk_sys);
        chk("irq masked", eventIrq, 1'b0);
        chk("stamp off", eventStampEnable, 1'b0);
        // pushes 2..9: half at four, full at eight, the ninth overflows
        for (int i = 2; i <= 9; i++) begin
            pulse(1'b1, 1'b0, 7'h00, 7'h00);
            rd(can_tef_pkg::ADDR_EVENT_STATUS);
            chk("status fill", rdVal, (i < 4) ? 16'h0001 : (i < 8) ? 16'h0003 : (i == 8) ? 16'h0007 : 16'h000F);
        end
        chk("head after overflow", eventWriteIdx, 8'h00);
        wr(can_tef_pkg::ADDR_EVENT_STATUS, 16'h0000);
        rd(can_tef_pkg::ADDR_EVENT_STATUS);
        chk("status write", rdVal, 16'h000F);
        // one enable at a time: only its own source may raise the line
        wr(can_tef_pkg::ADDR_EVENT_CONTROL, 16'h0008);
        repeat (3) @(posedge clk_sys);
        chk("irq overflow", eventIrq, 1'b1);
        pulse(1'b0, 1'b1, 7'h00, 7'h00);
        rd(can_tef_pkg::ADDR_EVENT_STATUS);
        chk("overflow clear", rdVal, 16'h0007);
        chk("irq overflow gone", eventIrq, 1'b0);
        wr(can_tef_pkg::ADDR_EVENT_CONTROL, 16'h0004);
        repeat (3) @(posedge clk_sys);
        chk("irq full", eventIrq, 1'b1);
        wr(can_tef_pkg::ADDR_EVENT_CONTROL, 16'h0122);
        repeat (2) @(posedge clk_sys);
        rd(can_tef_pkg::ADDR_EVENT_STATUS);
        chk("status advance", rdVal, 16'h0003);
        chk("irq half", eventIrq, 1'b1);
        expUa = EV_BASE + can_tef_pkg::EVENT_ELEM_BYTES + can_tef_pkg::EVENT_STAMP_BYTES;
        wr(can_tef_pkg::ADDR_EVENT_CONTROL, 16'h0020);
        repeat (2) @(posedge clk_sys);
        rd(can_tef_pkg::ADDR_EVENT_UA_LOW);
        chk("event ua low", rdVal, expUa[15:0]);
        // fifo1 gets two and loses one, fifo7 gets one
        pulse(1'b0, 1'b0, 7'h41, 7'h00);
        pulse(1'b0, 1'b0, 7'h01, 7'h00);
        pulse(1'b0, 1'b0, 7'h00, 7'h01);
        for (int d = 0; d < 2; d++) begin
            if (d == 1) begin
                wr(can_tef_pkg::ADDR_FIFO_DIR, 16'h007F);
            end
            for (int n = 1; n <= 7; n++) begin
                expUa = MSG_ELEM * 32'((n - 1) * MDEPTH + ((n == 1) ? d + 1 : (n == 7) ? d : 0));
                rd(can_tef_pkg::ADDR_MSG_UA_BASE + 6'(2 * n));
                chk("msg ua low", rdVal, expUa[15:0]);
                rd(can_tef_pkg::ADDR_MSG_UA_BASE + 6'(2 * n + 1));
                chk("msg ua high", rdVal, expUa[31:16]);
            end
        end
        rd(6'h3F);
        chk("unmapped", rdVal, 16'h0000);
        // stamp off: elements shrink back to the plain size
        wr(can_tef_pkg::ADDR_EVENT_CONTROL, 16'h0000);
        rd(can_tef_pkg::ADDR_EVENT_UA_LOW);
        expUa = EV_BASE + can_tef_pkg::EVENT_ELEM_BYTES;
        chk("event ua plain", rdVal, expUa[15:0]);
        // second reset in mid-run, with half and nonempty still set
        @(posedge clk_sys);
        reset_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        reset_n <= 1'b1;
        rd(can_tef_pkg::ADDR_EVENT_STATUS);
        chk("status second reset", rdVal, 16'h0000);
        finish_test();
    end
endmodule
